// ### rtl/lsp_pkg.sv
// Package: constants and types for the light-sensor parameter slice
package lsp_pkg;

  // ==========================================
  // Register offsets
  localparam logic [7:0] LSP_OFS_PERSIST  = 8'h19;
  localparam logic [7:0] LSP_OFS_BIAS     = 8'h1A;
  localparam logic [7:0] LSP_OFS_EMIT_REC = 8'h1C;
  localparam logic [7:0] LSP_OFS_IR_REC   = 8'h1D;
  localparam logic [7:0] LSP_OFS_IR_SCALE = 8'h1E;
  localparam logic [7:0] LSP_OFS_IR_MISC  = 8'h1F;
  localparam logic [7:0] LSP_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] LSP_OFS_IRQ_MASK = 8'h21;
  localparam logic [7:0] LSP_OFS_STATUS   = 8'h22;

  // ==========================================
  // Reset values
  localparam logic [7:0] LSP_RST_PERSIST  = 8'h03;
  localparam logic [7:0] LSP_RST_BIAS     = 8'h80;
  localparam logic [7:0] LSP_RST_EMIT_REC = 8'h00;
  localparam logic [7:0] LSP_RST_IR_REC   = 8'h70;
  localparam logic [7:0] LSP_RST_IR_SCALE = 8'h00;
  localparam logic [7:0] LSP_RST_IR_MISC  = 8'h00;

  // ==========================================
  // Field positions and masks
  localparam int         LSP_REC_SEL_LSB  = 4;
  localparam int         LSP_SPAN_BIT     = 5;
  localparam logic [7:0] LSP_REC_WMASK    = 8'h70;
  localparam logic [7:0] LSP_SCALE_WMASK  = 8'h07;
  localparam logic [7:0] LSP_MISC_WMASK   = 8'h3F;
  localparam logic [15:0] LSP_OVERRANGE   = 16'hFFFF;
  localparam logic [15:0] LSP_SAT_LIMIT   = 16'hFFFE;
  localparam int         LSP_IRQ_W        = 3;
  localparam int         LSP_IRQ_STATUS   = 0;
  localparam int         LSP_IRQ_RESULT   = 1;
  localparam int         LSP_IRQ_OVR      = 2;

  // ==========================================
  // Timing: one base ADC clock is 50 ns
  localparam int         LSP_CLK_NS       = 10;
  localparam int         LSP_ADC_CLK_NS   = 50;
  localparam int         LSP_ADC_DIV      = (LSP_ADC_CLK_NS + LSP_CLK_NS - 1) / LSP_CLK_NS;

  // ==========================================
  // Types
  typedef enum logic [1:0]
  {
    LSP_IDLE    = 2'b00,
    LSP_RECOVER = 2'b01,
    LSP_INTEG   = 2'b10
  } lsp_state_t;

  typedef struct packed
  {
    logic [15:0] raw;
    logic        exceed;
    logic        overrange;
  } lsp_sample_t;

  typedef struct packed
  {
    logic [15:0] data;
    logic        overrange;
  } lsp_result_t;

  typedef struct packed
  {
    logic [7:0] persist;
    logic [7:0] bias;
    logic [7:0] emit_rec;
    logic [7:0] ir_rec;
    logic [7:0] ir_scale;
    logic [7:0] ir_misc;
  } lsp_params_t;

endpackage

// ### rtl/lsp_bias_expand.sv
// Module: expands the 8-bit compressed bias code to 16 bits
`timescale 1ns/100ps
`default_nettype none
module lsp_bias_expand
  import lsp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Code in, value out
  input  wire logic [7:0]  code,
  output logic      [15:0] value
);

  typedef struct packed
  {
    logic [15:0] value;
  } lsp_exp_state_t;

  lsp_exp_state_t st_r;
  lsp_exp_state_t st_nxt;
  logic [31:0]    full;

  always_comb
  begin
    full   = {27'h0000000, 1'b1, code[3:0]} << code[7:4];
    st_nxt = st_r;
    st_nxt.value = (|full[31:20]) ? 16'hFFFF : full[19:4];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_r <= '{value: 16'h0100};
    else
      st_r <= st_nxt;
  end

  assign value = st_r.value;

endmodule
`default_nettype wire

// ### rtl/lsp_param_slice.sv
// Module: parameter slice with persistence filter, bias and IR timing
`timescale 1ns/100ps
`default_nettype none
module lsp_param_slice
  import lsp_pkg::*;
#(
  parameter int INTEG_CLKS = 16,
  parameter bit IR_PARAMS  = 1'b1
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Sample input from the threshold comparator
  input  wire logic              smp_valid,
  input  wire lsp_sample_t       smp,
  // Reported result
  output logic                   res_valid,
  output lsp_result_t            res,
  output logic                   amb_status,
  // IR conversion control
  input  wire logic              ir_start,
  output logic                   ir_busy,
  output logic                   ir_adc_tick,
  output logic                   ir_high_span,
  // Interrupt
  output logic                   irq
);

  // ==========================================
  // Parameter check
  generate
    if (INTEG_CLKS < 1 || INTEG_CLKS > 65535)
    begin : g_bad_integ
      $error("INTEG_CLKS out of range");
    end
  endgenerate

  // ==========================================
  // State
  typedef struct packed
  {
    lsp_params_t          prm;
    logic [7:0]           hist;
    logic                 status;
    logic                 res_valid;
    lsp_result_t          res;
    logic [7:0]           rdata;
    logic [LSP_IRQ_W-1:0] irq_stat;
    logic [LSP_IRQ_W-1:0] irq_mask;
    lsp_state_t           fsm;
    logic [9:0]           div_cnt;
    logic [15:0]          tick_cnt;
    logic                 tick;
  } lsp_state_s_t;

  lsp_state_s_t st_r;
  lsp_state_s_t st_nxt;
  logic [15:0]  bias_val;
  logic [16:0]  sum;
  logic [7:0]   hist_new;
  logic [7:0]   hist_hi;
  logic [7:0]   hist_lo;
  logic [2:0]   gain;
  logic [9:0]   div_end;
  logic [9:0]   rec_len;
  logic [LSP_IRQ_W-1:0] ev;

  // ==========================================
  // Persistence history
  // masked positions must all agree
  assign hist_new = {st_r.hist[6:0], smp.exceed};

  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_hist
      assign hist_hi[k] = ~st_r.prm.persist[k] | hist_new[k];
      assign hist_lo[k] = ~st_r.prm.persist[k] | ~hist_new[k];
    end
  endgenerate

  // ==========================================
  // Bias expansion
  // Registered, so a new code reaches results two cycles on
  // bias expansion
  lsp_bias_expand u_bias
  (
    .mclk  (mclk),
    .rst   (rst),
    .code  (st_r.prm.bias),
    .value (bias_val)
  );

  // ==========================================
  // Register read decode
  function automatic logic [7:0] rd_mux(input lsp_state_s_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      LSP_OFS_PERSIST:  v = s.prm.persist;
      LSP_OFS_BIAS:     v = s.prm.bias;
      LSP_OFS_EMIT_REC: v = s.prm.emit_rec;
      LSP_OFS_IR_REC:   v = s.prm.ir_rec;
      LSP_OFS_IR_SCALE: v = s.prm.ir_scale;
      LSP_OFS_IR_MISC:  v = s.prm.ir_misc;
      LSP_OFS_IRQ_STAT: v = {5'h00, s.irq_stat};
      LSP_OFS_IRQ_MASK: v = {5'h00, s.irq_mask};
      LSP_OFS_STATUS:   v = {5'h00, s.fsm != LSP_IDLE, s.status, |s.hist};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================
  // Recovery length decode
  // one clock, else two^(code+2) less one
  function automatic logic [9:0] rec_clocks(input logic [2:0] sel);
    logic [9:0] n;
    if (sel == 3'h0)
      n = 10'h001;
    else
      n = 10'((32'h0000_0001 << ({1'b0, sel} + 4'h2)) - 32'h0000_0001);
    return n;
  endfunction

  // ==========================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    ev     = '0;
    st_nxt.res_valid = 1'b0;
    st_nxt.tick      = 1'b0;

    // ==========================================
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        LSP_OFS_PERSIST:  st_nxt.prm.persist  = reg_wdata;
        LSP_OFS_BIAS:     st_nxt.prm.bias     = reg_wdata;
        LSP_OFS_EMIT_REC: st_nxt.prm.emit_rec = reg_wdata;
        LSP_OFS_IR_REC:   st_nxt.prm.ir_rec   = reg_wdata & LSP_REC_WMASK;
        LSP_OFS_IR_SCALE: st_nxt.prm.ir_scale = reg_wdata & LSP_SCALE_WMASK;
        // reserved low bits kept as written by host
        LSP_OFS_IR_MISC:  st_nxt.prm.ir_misc  = reg_wdata & LSP_MISC_WMASK;
        LSP_OFS_IRQ_MASK: st_nxt.irq_mask     = reg_wdata[LSP_IRQ_W-1:0];
        default:          st_nxt.prm          = st_r.prm;
      endcase
    end
    st_nxt.rdata = reg_rd ? rd_mux(st_r, reg_addr) : 8'h00;

    // ==========================================
    // Sample path
    // shift history of exceed flags
    sum      = {1'b0, smp.raw} + {1'b0, bias_val};
    if (smp_valid)
    begin
      st_nxt.hist = hist_new;
      if (st_r.prm.persist != 8'h00)
      begin
        if ((&hist_hi) && !st_r.status)
        begin
          st_nxt.status = 1'b1;
          ev[LSP_IRQ_STATUS] = 1'b1;
        end
        else if ((&hist_lo) && st_r.status)
        begin
          st_nxt.status = 1'b0;
          ev[LSP_IRQ_STATUS] = 1'b1;
        end
      end
      st_nxt.res_valid     = 1'b1;
      st_nxt.res.overrange = smp.overrange;
      if (smp.overrange)
      begin
        st_nxt.res.data = LSP_OVERRANGE;
        ev[LSP_IRQ_OVR] = 1'b1;
      end
      else if (sum > {1'b0, LSP_SAT_LIMIT})
        st_nxt.res.data = LSP_SAT_LIMIT;
      else
        st_nxt.res.data = sum[15:0];
      ev[LSP_IRQ_RESULT] = 1'b1;
    end

    // ==========================================
    // IR clock divider
    // defaults when IR parameters unsupported
    gain    = IR_PARAMS ? st_r.prm.ir_scale[2:0] : 3'h0;
    // ADC clock divide by two^gain
    // Wide enough for a divide of 640 at the top gain
    div_end = 10'((LSP_ADC_DIV << gain) - 1);
    rec_len = IR_PARAMS ? rec_clocks(st_r.prm.ir_rec[LSP_REC_SEL_LSB +: 3]) : 10'h001;

    // ==========================================
    // IR conversion sequencer
    unique case (st_r.fsm)
      LSP_IDLE:
      begin
        st_nxt.div_cnt  = '0;
        st_nxt.tick_cnt = '0;
        // Start only taken while idle
        if (ir_start)
          st_nxt.fsm = LSP_RECOVER;
      end
      LSP_RECOVER, LSP_INTEG:
      begin
        if (st_r.div_cnt >= div_end)
        begin
          st_nxt.div_cnt  = '0;
          st_nxt.tick     = 1'b1;
          st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
          if (st_r.fsm == LSP_RECOVER && st_r.tick_cnt + 16'h0001 >= {6'h00, rec_len})
          begin
            st_nxt.fsm      = LSP_INTEG;
            st_nxt.tick_cnt = '0;
          end
          else if (st_r.fsm == LSP_INTEG && st_r.tick_cnt + 16'h0001 >= 16'(INTEG_CLKS))
          begin
            st_nxt.fsm      = LSP_IDLE;
            st_nxt.tick_cnt = '0;
          end
        end
        else
          st_nxt.div_cnt = st_r.div_cnt + 10'h001;
      end
      // Unused code returns to idle
      default:
      begin
        st_nxt.fsm      = LSP_IDLE;
        st_nxt.div_cnt  = '0;
        st_nxt.tick_cnt = '0;
      end
    endcase

    // ==========================================
    // Interrupt status
    // Set wins so an event in the clear cycle is kept
    st_nxt.irq_stat = st_r.irq_stat;
    if (reg_wr && reg_addr == LSP_OFS_IRQ_STAT)
      st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[LSP_IRQ_W-1:0];
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r          <= '0;
      st_r.prm      <= '{persist: LSP_RST_PERSIST, bias: LSP_RST_BIAS,
                         emit_rec: LSP_RST_EMIT_REC, ir_rec: LSP_RST_IR_REC,
                         ir_scale: LSP_RST_IR_SCALE, ir_misc: LSP_RST_IR_MISC};
      st_r.fsm      <= LSP_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================
  // Outputs
  assign reg_rdata   = st_r.rdata;
  assign res_valid   = st_r.res_valid;
  assign res         = st_r.res;
  assign amb_status  = st_r.status;
  assign ir_busy     = (st_r.fsm != LSP_IDLE);
  assign ir_adc_tick = st_r.tick;
  assign ir_high_span = IR_PARAMS & st_r.prm.ir_misc[LSP_SPAN_BIT];
  assign irq         = |(st_r.irq_stat & st_r.irq_mask);

endmodule
`default_nettype wire

// ### verification/lsp_props.sv
// Checker: concurrent properties on the parameter slice ports
`timescale 1ns/100ps
`default_nettype none
module lsp_props
  import lsp_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  // Samples and results
  input wire logic        smp_valid,
  input wire lsp_sample_t smp,
  input wire logic        res_valid,
  input wire lsp_result_t res,
  input wire logic        amb_status,
  // IR control
  input wire logic        ir_start,
  input wire logic        ir_busy,
  input wire logic        ir_adc_tick,
  input wire logic        ir_high_span
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_tick_gap;
    !ir_adc_tick [*4];
  endsequence
  a_res_follows: assert property (smp_valid |=> res_valid)
    else $error("result strobe missing");
  a_bias_added: assert property (smp_valid && !smp.overrange && smp.raw < 16'hF000
    |=> res.data > $past(smp.raw)) else $error("bias not added");
  a_status_hold: assert property (!smp_valid |=> $stable(amb_status))
    else $error("status moved without sample");
  a_ovr_marker: assert property (res_valid && res.overrange |-> res.data == 16'hFFFF)
    else $error("overrange code wrong");
  a_no_false_ovr: assert property (res_valid && !res.overrange |-> res.data != 16'hFFFF)
    else $error("all-ones result without overrange");
  a_ovr_pass: assert property (smp_valid && smp.overrange |=> res.overrange)
    else $error("overrange lost");
  a_busy_start: assert property (ir_start && !ir_busy |=> ir_busy)
    else $error("start not taken");
  a_tick_gap: assert property (ir_adc_tick |=> s_tick_gap)
    else $error("ticks too close");
  a_span_write: assert property (reg_wr && reg_addr == 8'h1F
    |=> ir_high_span == $past(reg_wdata[5])) else $error("span bit not applied");
endmodule
bind lsp_param_slice lsp_props u_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .smp_valid(smp_valid), .smp(smp),
  .res_valid(res_valid), .res(res), .amb_status(amb_status), .ir_start(ir_start),
  .ir_busy(ir_busy), .ir_adc_tick(ir_adc_tick), .ir_high_span(ir_high_span));
`default_nettype wire

// ### verification/testbench.sv
// Testbench: register, sample path, interrupt and IR sequencer scenarios
`timescale 1ns/100ps
`default_nettype none
module testbench import lsp_pkg::*;;
  logic        mclk, rst, reg_wr, reg_rd, smp_valid, ir_start;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        res_valid, amb_status, ir_busy, ir_adc_tick, ir_high_span, irq;
  lsp_sample_t smp;
  lsp_result_t res;
  int          failures, tests_run, i;
  logic [7:0]  pm [3] = '{8'h03, 8'h07, 8'hFF};
  int          pn [3] = '{2, 3, 8};
  logic [2:0]  gn [3] = '{3'h0, 3'h4, 3'h6};
  logic [2:0]  sl [3] = '{3'h0, 3'h2, 3'h0};
  lsp_param_slice #(.INTEG_CLKS(4)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp(smp), .res_valid(res_valid), .res(res),
    .amb_status(amb_status), .ir_start(ir_start), .ir_busy(ir_busy),
    .ir_adc_tick(ir_adc_tick), .ir_high_span(ir_high_span), .irq(irq));
  // ==========================================
  // Tasks
  task summarize();
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task sample(input logic [15:0] raw, input logic ex, input logic ov);
    @(posedge mclk);
    smp <= '{raw, ex, ov};
    smp_valid <= 1'b1;
    @(posedge mclk);
    smp_valid <= 1'b0;
    #1 chk(res_valid, 1'b1);
  endtask
  task settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task ir_run(input logic [2:0] g, input logic [2:0] s);
    int n, ticks, t0, t1;
    wr(8'h1E, {5'h00, g});
    wr(8'h1D, {1'b0, s, 4'h0});
    @(posedge mclk);
    ir_start <= 1'b1;
    @(posedge mclk);
    ir_start <= 1'b0;
    #1 chk(ir_busy, 1'b1);
    ticks = 0;
    t0 = 0;
    t1 = 0;
    for (n = 1; n < 20000 && ir_busy === 1'b1; n++)
    begin
      @(posedge mclk);
      ir_start <= (n == 3);
      #1;
      if (ir_adc_tick === 1'b1)
      begin
        ticks++;
        if (ticks == 1) t0 = n;
        if (ticks == 2) t1 = n;
      end
    end
    if (n >= 20000)
      failures++;
    chk(17'(ticks), 17'(((s == 3'h0) ? 1 : (4 << s) - 1) + 4));
    chk(17'(t1 - t0), 17'(5 << g));
  endtask
  // ==========================================
  // Stimulus
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    {rst, reg_wr, reg_rd, smp_valid, ir_start} = 5'b10000;
    {reg_addr, reg_wdata, smp, failures, tests_run} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h19, 8'h03);
    rd(8'h1A, 8'h80);
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h70);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    wr(8'h1B, 8'h55);
    rd(8'h1B, 8'h00);
    wr(8'h1C, 8'hA5);
    rd(8'h1C, 8'hA5);
    wr(8'h1D, 8'hFF);
    rd(8'h1D, 8'h70);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h07);
    rd(8'h1F, 8'h00);
    wr(8'h1F, reg_rdata | 8'h20);
    rd(8'h1F, 8'h20);
    chk(ir_high_span, 1'b1);
    wr(8'h1F, 8'h1F);
    rd(8'h1F, 8'h1F);
    chk(ir_high_span, 1'b0);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h1A, 8'h60 + 8'(i * 16));
      settle();
      sample(16'h0100, 1'b0, 1'b0);
      chk(res, {16'h0100 + (16'd64 << i), 1'b0});
    end
    sample(16'h1234, 1'b0, 1'b1);
    chk(res, {16'hFFFF, 1'b1});
    sample(16'hFFF0, 1'b0, 1'b0);
    chk(res, {16'hFFFE, 1'b0});
    for (i = 0; i < 3; i++)
    begin
      wr(8'h19, pm[i]);
      repeat (pn[i]) sample(16'h0010, 1'b0, 1'b0);
      chk(amb_status, 1'b0);
      repeat (pn[i] - 1) sample(16'h0010, 1'b1, 1'b0);
      chk(amb_status, 1'b0);
      sample(16'h0010, 1'b1, 1'b0);
      chk(amb_status, 1'b1);
    end
    rd(8'h22, 8'h03);
    wr(8'h19, 8'h00);
    wr(8'h20, 8'h07);
    wr(8'h21, 8'h02);
    settle();
    chk(irq, 1'b0);
    sample(16'h0010, 1'b0, 1'b0);
    settle();
    chk(irq, 1'b1);
    rd(8'h20, 8'h02);
    wr(8'h21, 8'h00);
    settle();
    chk(irq, 1'b0);
    wr(8'h21, 8'h02);
    wr(8'h20, 8'h02);
    settle();
    chk(irq, 1'b0);
    rd(8'h20, 8'h00);
    for (i = 0; i < 3; i++)
      ir_run(gn[i], sl[i]);
    summarize();
  end
endmodule
`default_nettype wire
